// file: twsl_pkg.sv
// Purpose: shared constants and types of the two-wire slave block
// Assumes: 32-bit APB, register index times four gives byte address
// Notes: flag and control bit positions live here only
package twsl_pkg;
   // =========================================
   // register indices and byte addresses
   localparam logic [7:0] IDX_FLAGS = 8'h0b;
   localparam logic [7:0] IDX_OWN = 8'h0c;
   localparam logic [7:0] IDX_SHIFT = 8'h0d;
   localparam logic [7:0] IDX_MASK = 8'h0e;
   localparam logic [7:0] IDX_CTRL = 8'h10;
   localparam logic [7:0] A_FLAGS = {IDX_FLAGS[5:0], 2'b00};
   localparam logic [7:0] A_OWN = {IDX_OWN[5:0], 2'b00};
   localparam logic [7:0] A_SHIFT = {IDX_SHIFT[5:0], 2'b00};
   localparam logic [7:0] A_MASK = {IDX_MASK[5:0], 2'b00};
   localparam logic [7:0] A_CTRL = {IDX_CTRL[5:0], 2'b00};
   // =========================================
   // flag register bit positions
   localparam int FB_DONE = 7;
   localparam int FB_MATCH = 6;
   localparam int FB_HOLD = 5;
   localparam int FB_LAST_MASTER_ACK = 4;
   localparam int FB_CLASH = 3;
   localparam int FB_BERR = 2;
   localparam int FB_DIR = 1;
   localparam int FB_CAUSE = 0;
   // =========================================
   // control register bit positions
   localparam int CB_SLV_EN = 0;
   localparam int CB_PROMISCUOUS_MATCH_ENABLE = 2;
   localparam int CB_STOP_IE = 5;
   localparam int CB_MS_IE = 6;
   localparam int CB_BD_IE = 7;
   localparam int CB_MST_EN = 8;
   localparam int CB_ACK = 10;
   localparam int CB_CMD = 12;
   localparam logic [1:0] CMD_COMPTRANS = 2'h2;
   localparam logic [1:0] CMD_RESPONSE = 2'h3;
   // =========================================
   // reset values and counts
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [10:0] RST_CTRL = 11'h000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_HOLD_A = 3'b010,
      ST_ACK = 3'b011,
      ST_RX = 3'b100,
      ST_TX = 3'b101,
      ST_MACK = 3'b110,
      ST_HOLD_D = 3'b111
   } twsl_state_t;
endpackage

// file: twsl_line_if.sv
// Purpose: synchronised bus line levels and detected events
// Assumes: all signals in the pclk domain
// Notes: produced by the condition detector, consumed by the engine
`timescale 1ns/10ps
`default_nettype none
interface twsl_line_if;
   logic scl;
   logic sda;
   logic start_p;
   logic stop_p;
   logic scl_rise;
   logic scl_fall;
   modport drv (output scl, sda, start_p, stop_p, scl_rise, scl_fall);
   modport mon (input scl, sda, start_p, stop_p, scl_rise, scl_fall);
endinterface
`default_nettype wire

// file: twsl_cond.sv
// Purpose: synchronise scl and sda, find edges, start and stop
// Assumes: pclk at least four times the scl rate
// Notes: first sync stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module twsl_cond (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl_in,
   input wire logic sda_in,
   twsl_line_if.drv line
);
   import twsl_pkg::*;
   logic [2:0] scl_d;
   logic [2:0] sda_d;
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   // =========================================
   // shift chains, idle bus reads high
   always_comb
   begin
      scl_d = {scl_q[1:0], scl_in};
      sda_d = {sda_q[1:0], sda_in};
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end
      else
      begin
         scl_q <= scl_d;
         sda_q <= sda_d;
      end
   end
   // =========================================
   // events from stages two and three only
   assign line.scl = scl_q[1];
   assign line.sda = sda_q[1];
   assign line.scl_rise = scl_q[1] & ~scl_q[2];
   assign line.scl_fall = ~scl_q[1] & scl_q[2];
   assign line.start_p = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign line.stop_p = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule
`default_nettype wire

// file: twsl_match.sv
// Purpose: own-address recognition for the first address byte
// Assumes: address byte already shifted in, read bit excluded
// Notes: ten-bit first bytes match as ordinary seven-bit patterns
`timescale 1ns/10ps
`default_nettype none
module twsl_match (
   input wire logic [6:0] rx_id,
   input wire logic [7:0] own_id,
   input wire logic [7:0] id_mask,
   input wire logic promisc,
   output logic hit
);
   import twsl_pkg::*;
   logic second_id_select;
   logic masked_ok;
   logic second_ok;
   logic gcall_ok;
   // =========================================
   // compare paths
   always_comb
   begin
      second_id_select = id_mask[0];
      masked_ok = ~second_id_select &
         (((rx_id ^ own_id[7:1]) & ~id_mask[7:1]) == 7'h00);
      second_ok = (rx_id == own_id[7:1]) |
         (second_id_select & (rx_id == id_mask[7:1]));
      // general call needs bit zero set
      gcall_ok = own_id[0] & (rx_id == 7'h00);
      hit = promisc | masked_ok | second_ok | gcall_ok;
   end
endmodule
`default_nettype wire

// file: twsl_top.sv
// Purpose: two-wire slave with status, own id, shift port and mask
// Assumes: APB with zero wait states; pins synchronised inside
// Notes: second byte of ten-bit addresses is left to software
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module twsl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);
   import twsl_pkg::*;
   twsl_line_if line ();
   twsl_state_t st_q, st_d, nxt_q, nxt_d;
   logic [7:0] own_q, own_d, mask_q, mask_d, shreg_q, shreg_d;
   logic [10:0] ctrl_q, ctrl_d;
   logic [3:0] cnt_q, cnt_d;
   logic dif_q, dif_d, match_or_stop_flag_q, match_or_stop_flag_d, tx_clash_flag_q, tx_clash_flag_d, berr_q, berr_d;
   logic last_master_ack_q, last_master_ack_d, dir_q, dir_d, cause_q, cause_d;
   logic nack_q, nack_d, drv_q, drv_d;
   logic [31:0] prdata_q, prdata_d;
   logic acc, wr, rd, mapped, wr_shift, acc_shift, cmd_ok, clr, trig;
   logic hold, hit, slv_en, mst_en, set_dif, set_match_or_stop_flag, set_tx_clash_flag, set_berr;
   logic [1:0] cmd;
   logic [7:0] flags;

   // =========================================
   // line conditioning and address matching
   twsl_cond u_cond (
      .pclk(pclk),
      .presetn(presetn),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line.drv)
   );
   twsl_match u_match (
      .rx_id(shreg_q[7:1]),
      .own_id(own_q),
      .id_mask(mask_q),
      .promisc(ctrl_q[CB_PROMISCUOUS_MATCH_ENABLE]),
      .hit(hit)
   );

   // =========================================
   // bus decode, zero wait states
   always_comb
   begin
      acc = psel & penable;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      mapped = (paddr == A_FLAGS) | (paddr == A_OWN) | (paddr == A_SHIFT) |
         (paddr == A_MASK) | (paddr == A_CTRL);
      cmd = pwdata[CB_CMD +: 2];
      slv_en = ctrl_q[CB_SLV_EN];
      mst_en = ctrl_q[CB_MST_EN];
      hold = (st_q == ST_HOLD_A) | (st_q == ST_HOLD_D);
      wr_shift = wr & (paddr == A_SHIFT);
      acc_shift = acc & (paddr == A_SHIFT);
      cmd_ok = wr & (paddr == A_CTRL) & ((cmd == CMD_COMPTRANS) | (cmd == CMD_RESPONSE));
      clr = acc_shift | cmd_ok;
      trig = hold & clr;
      flags = {dif_q, match_or_stop_flag_q, hold & (dif_q | match_or_stop_flag_q), last_master_ack_q, tx_clash_flag_q, berr_q,
         dir_q, cause_q};
   end
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata = prdata_q;

   // =========================================
   // read data is captured in the setup cycle
   always_comb
   begin
      prdata_d = prdata_q;
      if (psel & ~penable)
      begin
         prdata_d = 32'h0000_0000;
         case (paddr)
            A_FLAGS: prdata_d[7:0] = flags;
            A_OWN: prdata_d[7:0] = own_q;
            // direct view of the shift register
            A_SHIFT: prdata_d[7:0] = shreg_q;
            A_MASK: prdata_d[7:0] = mask_q;
            A_CTRL: prdata_d[10:0] = {ctrl_q[10:2], 2'b00} | {9'h000, ctrl_q[1:0]};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // =========================================
   // control registers; command field is a strobe, not stored
   always_comb
   begin
      own_d = own_q;
      mask_d = mask_q;
      ctrl_d = ctrl_q;
      if (wr & (paddr == A_OWN))
         own_d = pwdata[7:0];
      if (wr & (paddr == A_MASK))
         mask_d = pwdata[7:0];
      if (wr & (paddr == A_CTRL))
         ctrl_d = pwdata[10:0];
   end

   // =========================================
   // bit engine and flags; set beats clear in the same cycle
   always_comb
   begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      shreg_d = shreg_q;
      last_master_ack_d = last_master_ack_q;
      dir_d = dir_q;
      cause_d = cause_q;
      nack_d = nack_q;
      set_dif = 1'b0;
      set_match_or_stop_flag = 1'b0;
      set_tx_clash_flag = 1'b0;
      set_berr = 1'b0;
      case (st_q)
         ST_ADDR, ST_RX:
         begin
            if (line.scl_rise)
            begin
               shreg_d = {shreg_q[6:0], line.sda};
               cnt_d = cnt_q + 4'h1;
            end
            else if (line.scl_fall && cnt_q == BITS_PER_BYTE)
            begin
               cnt_d = 4'h0;
               if (st_q == ST_RX)
               begin
                  set_dif = 1'b1;
                  st_d = ST_HOLD_D;
               end
               else if (hit)
               begin
                  set_match_or_stop_flag = 1'b1;
                  cause_d = 1'b1;
                  dir_d = shreg_q[0];
                  st_d = ST_HOLD_A;
               end
               else
                  st_d = ST_IDLE;
            end
         end
         ST_ACK:
         begin
            if (line.scl_rise && nack_q && !line.sda)
               set_tx_clash_flag = 1'b1;
            if (line.scl_fall)
            begin
               st_d = nxt_q;
               // done flag set even after clash
               set_dif = (nxt_q == ST_HOLD_D);
            end
         end
         ST_TX:
         begin
            if (line.scl_rise && shreg_q[7] && !line.sda)
               set_tx_clash_flag = 1'b1;
            if (line.scl_fall)
            begin
               shreg_d = {shreg_q[6:0], 1'b1};
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == BITS_PER_BYTE - 4'h1)
               begin
                  cnt_d = 4'h0;
                  st_d = ST_MACK;
               end
            end
         end
         ST_MACK:
         begin
            if (line.scl_rise)
               last_master_ack_d = line.sda;
            if (line.scl_fall)
            begin
               set_dif = 1'b1;
               st_d = ST_HOLD_D;
            end
         end
         ST_HOLD_A, ST_HOLD_D:
         begin
            if (wr_shift)
               shreg_d = pwdata[7:0];
            if (trig)
            begin
               nack_d = ctrl_q[CB_ACK];
               if (cmd_ok && cmd == CMD_COMPTRANS)
               begin
                  st_d = dir_q ? ST_IDLE : ST_ACK;
                  nxt_d = ST_IDLE;
               end
               else if (st_q == ST_HOLD_D && dir_q)
                  st_d = ST_TX;
               else
               begin
                  st_d = ST_ACK;
                  nxt_d = ctrl_q[CB_ACK] ? ST_IDLE : (dir_q ? ST_HOLD_D : ST_RX);
               end
            end
         end
         ST_IDLE:
            cnt_d = 4'h0;
         default:
            st_d = ST_IDLE;
      endcase
      // start-stop or mid-byte; a legal stop or restart follows one receive rise
      if (mst_en && (line.start_p || line.stop_p) &&
         ((st_q == ST_ADDR && (cnt_q != 4'h0 || line.stop_p)) ||
         (st_q == ST_RX && cnt_q > 4'h1) || (st_q == ST_TX && cnt_q != 4'h0)))
         set_berr = 1'b1;
      if (line.start_p)
      begin
         st_d = ST_ADDR;
         cnt_d = 4'h0;
         set_dif = 1'b0;
      end
      else if (line.stop_p)
      begin
         st_d = ST_IDLE;
         set_dif = 1'b0;
         set_match_or_stop_flag = ctrl_q[CB_STOP_IE];
         cause_d = ctrl_q[CB_STOP_IE] ? 1'b0 : cause_q;
      end
      if (!slv_en)
      begin
         st_d = ST_IDLE;
         set_dif = 1'b0;
         set_match_or_stop_flag = 1'b0;
         set_tx_clash_flag = 1'b0;
      end
      dif_d = set_dif | (dif_q & ~clr & ~(wr & (paddr == A_FLAGS) & pwdata[FB_DONE]));
      match_or_stop_flag_d = set_match_or_stop_flag | (match_or_stop_flag_q & ~clr & ~(wr & (paddr == A_FLAGS) & pwdata[FB_MATCH]));
      tx_clash_flag_d = set_tx_clash_flag | (tx_clash_flag_q & ~line.start_p &
         ~(wr & (paddr == A_FLAGS) & pwdata[FB_CLASH]));
      berr_d = set_berr | (berr_q & ~(wr & (paddr == A_FLAGS) & pwdata[FB_BERR]));
      drv_d = ~tx_clash_flag_d & (((st_d == ST_ACK) & ~nack_d) | ((st_d == ST_TX) & ~shreg_d[7]));
   end

   // =========================================
   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         shreg_q <= RST_BYTE;
         own_q <= RST_BYTE;
         mask_q <= RST_BYTE;
         ctrl_q <= RST_CTRL;
         {dif_q, match_or_stop_flag_q, tx_clash_flag_q, berr_q} <= 4'h0;
         {last_master_ack_q, dir_q, cause_q, nack_q, drv_q} <= 5'h00;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         st_q <= st_d;
         nxt_q <= nxt_d;
         cnt_q <= cnt_d;
         shreg_q <= shreg_d;
         own_q <= own_d;
         mask_q <= mask_d;
         ctrl_q <= ctrl_d;
         {dif_q, match_or_stop_flag_q, tx_clash_flag_q, berr_q} <= {dif_d, match_or_stop_flag_d, tx_clash_flag_d, berr_d};
         {last_master_ack_q, dir_q, cause_q, nack_q, drv_q} <= {last_master_ack_d, dir_d, cause_d, nack_d, drv_d};
         prdata_q <= prdata_d;
      end
   end

   // =========================================
   // pins; open drain, so the driven level is always low
   // stretch while a flag holds
   assign scl_oe = hold & (dif_q | match_or_stop_flag_q);
   assign scl_out = 1'b0;
   assign sda_oe = drv_q;
   assign sda_out = 1'b0;
   assign irq = (dif_q & ctrl_q[CB_BD_IE]) | (match_or_stop_flag_q & ctrl_q[CB_MS_IE]);

   // =========================================
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_DONE_SET: assert property ((st_q == ST_RX) && line.scl_fall && (cnt_q == 4'h8)
      && slv_en && !line.start_p && !line.stop_p |=> dif_q && st_q == ST_HOLD_D)
      else $error("byte done not flagged");
   AST_DONE_W1C: assert property ((st_q == ST_HOLD_D) && wr && (paddr == A_FLAGS) &&
      pwdata[FB_DONE] && !line.start_p && !line.stop_p |=> !dif_q)
      else $error("byte done not cleared by write one");
   AST_AUTO_CLR: assert property (hold && acc_shift && !line.stop_p |=> !dif_q && !match_or_stop_flag_q)
      else $error("flags survived shift port access");
   AST_MATCH_SET: assert property ((st_q == ST_ADDR) && line.scl_fall && (cnt_q == 4'h8)
      && hit && slv_en && !line.start_p && !line.stop_p |=> match_or_stop_flag_q && cause_q && scl_oe)
      else $error("address match not flagged");
   AST_HOLD_SCL: assert property ((st_q == ST_MACK) && line.scl_fall && slv_en
      && !line.start_p && !line.stop_p |=> scl_oe && flags[FB_HOLD])
      else $error("clock not held after byte done");
   AST_CLASH_QUIET: assert property (tx_clash_flag_q && $past(tx_clash_flag_q) |-> !sda_oe)
      else $error("low driven during clash");
   AST_START_CLR: assert property (line.start_p |=> !tx_clash_flag_q ##1 (st_q == ST_ADDR || !slv_en))
      else $error("start did not clear clash");
   AST_BERR_SET: assert property (mst_en && line.stop_p && (st_q == ST_ADDR) |=> berr_q)
      else $error("start then stop not flagged");
   AST_BERR_OFF: assert property (!mst_en && !berr_q |=> !berr_q)
      else $error("bus error without master enable");
   AST_SHIFT_BLOCK: assert property (wr_shift && (st_q == ST_IDLE) |=> $stable(shreg_q))
      else $error("shift write not blocked");
   COV_MATCH: cover property (st_q == ST_ADDR ##1 st_q == ST_HOLD_A);
   COV_RX: cover property (st_q == ST_RX ##[1:400] st_q == ST_HOLD_D);
   COV_TX: cover property (st_q == ST_MACK ##1 st_q == ST_HOLD_D);
   COV_CLASH: cover property (tx_clash_flag_q && st_q == ST_TX);
endmodule
`default_nettype wire

// file: twsl_i2c_master.sv
// Purpose: two-wire bus master model for the slave bench
// Assumes: pull-ups on both lines are resolved by the bench
// Notes: a stretch wait lasts until the bench watchdog ends the run
`timescale 1ns/10ps
`default_nettype none
module twsl_i2c_master (
   input wire logic scl,
   input wire logic sda,
   output var logic scl_low,
   output var logic sda_low
);
   localparam realtime Q = 31.25;
   // ==========================================
   // line steps, a quarter link period each
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic rise();
      scl_low = 1'b0;
      while (scl !== 1'b1)
         #5;
      #Q;
   endtask
   // sda falls while scl is high
   task automatic start();
      sda_low = 1'b1;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask
   // sda rises while scl is high
   task automatic stop();
      sda_low = 1'b1;
      #Q;
      rise();
      sda_low = 1'b0;
      #Q;
   endtask
   // data set in the low phase, sampled in the high phase
   task automatic bit_x(input logic b, output logic r);
      sda_low = ~b;
      #Q;
      rise();
      r = sda;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask
   // msb first, then the acknowledge slot
   task automatic byte_x(input logic [7:0] d, input logic ma, output logic [7:0] r,
      output logic a);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(ma, a);
   endtask
endmodule
`default_nettype wire

// file: two_wire_slave_status_addr_data_bench.sv
// Purpose: self-checking bench of the two-wire slave block
// Assumes: master model on the bus, APB driven by the bench
// Notes: reads queue their expectation for the monitor
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_status_addr_data_bench;
   import twsl_pkg::*;
   typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} twsl_note_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, ack;
   logic [7:0] dat, rnd, r8;
   logic [32:0] tbl [7];
   int err_count = 0;
   int checked = 0;
   twsl_note_t notes [$];
   twsl_note_t nt;
   // open drain lines, pulled up when nobody drives
   wire scl_w = (scl_oe ? scl_out : 1'b1) & ~m_scl;
   wire sda_w = (sda_oe ? sda_out : 1'b1) & ~m_sda;
   always #2.5 pclk = ~pclk;
   twsl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   twsl_i2c_master u_mst (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
   // ==========================================
   // checking and bus tasks
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s,
      input logic [31:0] m);
      checked++;
      if (((s ^ e) & m) !== 32'h0)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", w, e & m, s & m);
      end
   endtask
   // hold the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
      input logic e = 1'b0);
      notes.push_back({v, m, e});
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // first edge skipped so a flag cleared just now is not seen
   task automatic wait_irq();
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (irq !== 1'b1 && n < 8000);
      chk("irq", 32'h1, {31'h0, irq}, 32'h1);
   endtask
   task automatic close_out();
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // monitor: each completed read takes the oldest note
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
      begin
         nt = notes.pop_front();
         chk("prdata", nt.v, prdata, nt.m);
         chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr}, 32'h1);
      end
   // watchdog, far beyond the expected run
   initial
   begin
      #200000;
      err_count++;
      close_out();
   end
   // ==========================================
   // scenarios
   initial
   begin
      void'($urandom(74));
      rnd = 8'h40 | 8'($urandom() % 16);
      dat = 8'($urandom());
      tbl = '{{1'b0, 8'h54, 8'h00, 8'h00, rnd}, {1'b1, 8'h54, 8'h02, 8'h00, 8'h2b},
         {1'b1, 8'h54, 8'h23, 8'h00, 8'h11}, {1'b1, 8'h55, 8'h00, 8'h00, 8'h00},
         {1'b0, 8'h54, 8'h00, 8'h00, 8'h00}, {1'b1, 8'h54, 8'h00, 8'h04, 8'h17},
         {1'b1, 8'hf4, 8'h00, 8'h00, 8'h7a}};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, index 0x0f unmapped
      for (int i = 11; i < 17; i++)
         rd(8'(i * 4), 32'h0, '1, i == 15);
      // shift port write while idle must not land
      wr(A_SHIFT, 32'ha5);
      rd(A_SHIFT, 32'h0, '1);
      wr(A_OWN, 32'h54);
      wr(A_CTRL, 32'he1);
      // master write: address, one data byte, stop
      fork
         begin
            u_mst.start();
            u_mst.byte_x(8'h54, 1'b1, r8, ack);
            chk("addr ack", 32'h0, {31'h0, ack}, 32'h1);
            u_mst.byte_x(dat, 1'b1, r8, ack);
            chk("data ack", 32'h0, {31'h0, ack}, 32'h1);
            u_mst.stop();
         end
         begin
            wait_irq();
            rd(A_FLAGS, 32'h61, 32'he3);
            wr(A_CTRL, 32'h30e1);
            wait_irq();
            rd(A_FLAGS, 32'ha0, 32'he2);
            rd(A_SHIFT, {24'h0, dat}, '1);
            wait_irq();
            rd(A_FLAGS, 32'h40, 32'he1);
         end
      join
      wr(A_FLAGS, 32'h0);
      rd(A_FLAGS, 32'h40, 32'hc0);
      wr(A_FLAGS, 32'h40);
      rd(A_FLAGS, 32'h0, 32'hc0);
      wr(A_CTRL, 32'hc1);
      // master read: two bytes, acknowledged then refused
      fork
         begin
            u_mst.start();
            u_mst.byte_x(8'h55, 1'b1, r8, ack);
            u_mst.byte_x(8'hff, 1'b0, r8, ack);
            chk("tx byte", {24'h0, dat}, {24'h0, r8}, '1);
            u_mst.byte_x(8'hff, 1'b1, r8, ack);
            chk("tx byte", {24'h0, ~dat}, {24'h0, r8}, '1);
            u_mst.stop();
         end
         begin
            wait_irq();
            rd(A_FLAGS, 32'h63, 32'he3);
            wr(A_CTRL, 32'h30c1);
            wait_irq();
            rd(A_FLAGS, 32'ha2, 32'he2);
            wr(A_SHIFT, {24'h0, dat});
            wait_irq();
            rd(A_FLAGS, 32'ha2, 32'hb2);
            wr(A_SHIFT, {24'h0, ~dat});
            wait_irq();
            rd(A_FLAGS, 32'hb2, 32'hb2);
            wr(A_FLAGS, 32'h80);
            rd(A_FLAGS, 32'h0, 32'ha0);
         end
      join
      // master read of ones while the master pulls low: clash, then a start
      fork
         begin
            u_mst.start();
            u_mst.byte_x(8'h55, 1'b1, r8, ack);
            u_mst.byte_x(8'h00, 1'b1, r8, ack);
            u_mst.stop();
            u_mst.start();
            u_mst.stop();
         end
         begin
            wait_irq();
            wr(A_CTRL, 32'h30c1);
            wait_irq();
            wr(A_SHIFT, 32'hff);
            wait_irq();
            rd(A_FLAGS, 32'hba, 32'hfe);
            wr(A_FLAGS, 32'h80);
         end
      join
      rd(A_FLAGS, 32'h0, 32'h08);
      // address table: miss, mask, second id, general call, promiscuous, ten-bit
      foreach (tbl[i])
      begin
         wr(A_OWN, {24'h0, tbl[i][31:24]});
         wr(A_MASK, {24'h0, tbl[i][23:16]});
         rd(A_MASK, {24'h0, tbl[i][23:16]}, '1);
         wr(A_CTRL, {24'h0, tbl[i][15:8] | 8'h41});
         fork
            begin
               u_mst.start();
               u_mst.byte_x({tbl[i][6:0], 1'b0}, 1'b1, r8, ack);
               u_mst.stop();
            end
            if (tbl[i][32])
            begin
               wait_irq();
               wr(A_CTRL, {24'h0, tbl[i][15:8] | 8'h41} | 32'h2000);
            end
         join
         chk("match ack", {31'h0, ~tbl[i][32]}, {31'h0, ack}, 32'h1);
      end
      rd(A_FLAGS, 32'h0, 32'he0);
      // start straight into stop, with and without the master half
      for (int i = 0; i < 2; i++)
      begin
         wr(A_CTRL, i ? 32'h101 : 32'h1);
         u_mst.start();
         u_mst.stop();
         rd(A_FLAGS, {29'h0, 1'(i), 2'h0}, 32'h04);
         wr(A_FLAGS, 32'h04);
      end
      rd(A_FLAGS, 32'h0, 32'h04);
      close_out();
   end
endmodule
`default_nettype wire
